// ---- sapc_analog_model.sv ----
`timescale 1ns/1ns

// ============================================================
// Analog far side: sample-hold, tap string and comparator
module sapc_analog_model
(
    input wire logic core_clk,
    input wire logic [2:0] channelSel,
    input wire logic sampleHold,
    input wire logic [9:0] tapCode,
    input wire logic [9:0] chanLevel [8],
    output logic compIn
);
    logic [9:0] heldLevel;

    // Track the selected input while sampling; freeze it during hold so
    // a level change mid-conversion only reaches the next conversion
    always @(posedge core_clk)
    begin
        if (!sampleHold)
            heldLevel <= chanLevel[channelSel];
    end

    // Ideal comparator, 1 when the held input is at or above the tap
    assign compIn = (heldLevel >= tapCode);
endmodule : sapc_analog_model

// ---- sapc_control.sv ----
// Operation
// - Threshold is compared with the upper eight result bits only
// - Threshold is an 8-bit read/write byte, cleared by reset
// - Sample the input, then hold until the conversion finishes
// - First trial sets bit 9 at half scale, kept if input >= tap
// - Later trials set next bit; keep it when input >= tap
// - After bit 0 the value is latched as result, interrupt possible
// - Result reads left-justified, value times 64, low six bits zero
// - Conversions repeat back to back until the run bit clears
// - Control register write aborts; restarts if still running
// - Clearing the run bit stops at once; result undefined
// - Powerfail mode bit 7 picks plain conversion or comparison
// - Normal mode stores every result and raises the interrupt
// - Polarity 0 interrupts only when upper bits >= threshold
// - Polarity 1 interrupts only when upper bits < threshold
// - An unread result is overwritten by the newer one
// - One of eight inputs is converted per conversion
// - Time code selects 288/240/192/144/120/96 clocks
// - A result read colliding with latch wins; latch follows
// - A control write colliding with latch cancels latch and irq
`timescale 1ns/1ns
`include "sapc_params.svh"

module sapc_control
    import sapc_pkg::*;
(
    input wire logic core_clk,
    input wire logic reset,
    input wire logic [15:0] busAddr,
    input wire logic busWrite,
    input wire logic busRead,
    input wire logic [7:0] busWrData,
    output logic [7:0] busRdData,
    input wire logic compIn,
    output logic [2:0] channelSel,
    output logic sampleHold,
    output logic [9:0] tapCode,
    output logic refGenEnable,
    output logic conversionEndIrq
);

    // ========================================================
    // Register state
    logic [7:0] modeReg;
    logic [2:0] chanReg;
    logic pfEnReg;
    logic pfPolReg;
    logic [7:0] threshReg;
    sapc_code_t resultReg;
    sapc_code_t pendReg;
    logic pendValidReg;
    logic irqReg;
    logic [7:0] rdDataReg;
    logic [7:0] rdDataNext;
    logic restartReg;
    logic [2:0] compSync;
    logic compFiltReg;

    logic isMode;
    logic isChan;
    logic isPfm;
    logic isPft;
    logic isResLo;
    logic isResHi;
    logic ctrlWrite;
    logic resultRead;
    logic doneOk;
    logic commitNow;
    sapc_code_t commitVal;
    logic [4:0] unitCount;

    sapc_eng_if eng();

    sapc_sar_engine engine
    (
        .core_clk(core_clk),
        .reset(reset),
        .bus(eng)
    );

    // ========================================================
    // Interrupt qualification
    function automatic logic sapc_irq_hit(
        input sapc_code_t v,
        input logic [7:0] th,
        input logic en,
        input logic pol
    );
        logic hit;
        if (!en)
        begin
            hit = 1'b1;
        end
        else if (!pol)
        begin
            hit = (v[9:2] >= th);
        end
        else
        begin
            hit = (v[9:2] < th);
        end
        return hit;
    endfunction : sapc_irq_hit

    // ========================================================
    // Address decode
    assign isMode = (busAddr == `SAPC_ADDR_MODE);
    assign isChan = (busAddr == `SAPC_ADDR_CHAN);
    assign isPfm = (busAddr == `SAPC_ADDR_PFM);
    assign isPft = (busAddr == `SAPC_ADDR_PFT);
    assign isResLo = (busAddr == `SAPC_ADDR_RES_LO);
    assign isResHi = (busAddr == `SAPC_ADDR_RES_HI);
    assign ctrlWrite = busWrite && (isMode || isChan || isPfm || isPft);
    assign resultRead = busRead && (isResLo || isResHi);

    // A finishing conversion is dropped when a control write lands
    // in the same cycle, so neither result nor interrupt appear
    assign doneOk = eng.done && !ctrlWrite;

    // The read sees the old result; a deferred value lands after it
    assign commitNow = !resultRead && (doneOk || pendValidReg);
    assign commitVal = doneOk ? eng.value : pendReg;

    // ========================================================
    // Conversion time selection
    always_comb
    begin
        case (modeReg[`SAPC_FR_MSB:`SAPC_FR_LSB])
            3'h0: unitCount = `SAPC_UNIT_288;
            3'h1: unitCount = `SAPC_UNIT_240;
            3'h2: unitCount = `SAPC_UNIT_192;
            3'h4: unitCount = `SAPC_UNIT_144;
            3'h5: unitCount = `SAPC_UNIT_120;
            3'h6: unitCount = `SAPC_UNIT_96;
            // Prohibited codes fall back to the slowest, safest time
            default: unitCount = `SAPC_UNIT_288;
        endcase
    end

    assign eng.run = modeReg[`SAPC_RUN_BIT];
    assign eng.restart = restartReg;
    assign eng.unit = unitCount;
    assign eng.compare = compFiltReg;

    // ========================================================
    // Register writes
    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            modeReg <= `SAPC_MODE_RST;
            chanReg <= `SAPC_CHAN_RST;
            pfEnReg <= 1'b0;
            pfPolReg <= 1'b0;
            threshReg <= `SAPC_PFT_RST;
        end
        else if (busWrite)
        begin
            if (isMode)
            begin
                modeReg <= busWrData & `SAPC_MODE_MASK;
            end
            else if (isChan)
            begin
                chanReg <= busWrData[2:0];
            end
            else if (isPfm)
            begin
                pfEnReg <= busWrData[`SAPC_POWERFAIL_COMPARE_ENABLE_BIT];
                pfPolReg <= busWrData[`SAPC_PFPOL_BIT];
            end
            else if (isPft)
            begin
                threshReg <= busWrData;
            end
        end
    end

    // Every control write restarts the sequence on the next cycle if the run bit is still set
    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            restartReg <= 1'b0;
        end
        else
        begin
            restartReg <= ctrlWrite;
        end
    end

    // ========================================================
    // Comparator input: three stages, accepted when the last two agree
    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            compSync <= 3'h0;
            compFiltReg <= 1'b0;
        end
        else
        begin
            compSync <= {compSync[1:0], compIn};
            if (compSync[1] == compSync[2])
            begin
                compFiltReg <= compSync[2];
            end
        end
    end

    // ========================================================
    // Result latch and interrupt
    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            resultReg <= 10'h000;
            pendReg <= 10'h000;
            pendValidReg <= 1'b0;
            irqReg <= 1'b0;
        end
        else
        begin
            irqReg <= 1'b0;
            if (doneOk && resultRead)
            begin
                pendReg <= eng.value;
                pendValidReg <= 1'b1;
            end
            else if (commitNow)
            begin
                pendValidReg <= 1'b0;
            end
            if (commitNow)
            begin
                // Unread results are simply replaced
                resultReg <= commitVal;
                irqReg <= sapc_irq_hit(commitVal, threshReg,
                                       pfEnReg, pfPolReg);
            end
        end
    end

    // ========================================================
    // Read mux
    always_comb
    begin
        rdDataNext = 8'h00;
        if (isMode)
        begin
            rdDataNext = modeReg;
        end
        else if (isChan)
        begin
            rdDataNext = {5'h00, chanReg};
        end
        else if (isPfm)
        begin
            rdDataNext = {pfEnReg, pfPolReg, 6'h00};
        end
        else if (isPft)
        begin
            rdDataNext = threshReg;
        end
        else if (isResLo)
        begin
            rdDataNext = {resultReg[1:0], 6'h00};
        end
        else if (isResHi)
        begin
            rdDataNext = resultReg[9:2];
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            rdDataReg <= 8'h00;
        end
        else if (busRead)
        begin
            rdDataReg <= rdDataNext;
        end
    end

    // ========================================================
    // Outputs
    assign busRdData = rdDataReg;
    assign conversionEndIrq = irqReg;
    assign channelSel = chanReg;
    assign refGenEnable = modeReg[`SAPC_REF_BIT];
    assign sampleHold = eng.hold;
    assign tapCode = eng.tap;

    // ========================================================
    // Checks
    thresh_reset_a: assert property (@(posedge core_clk)
        reset |=> threshReg == 8'h00)
        else $error("threshold not cleared by reset");

    result_latch_a: assert property (@(posedge core_clk) disable iff (reset)
        eng.done && !ctrlWrite && !resultRead
        |=> resultReg == $past(eng.value))
        else $error("result not latched at conversion end");

    read_first_a: assert property (@(posedge core_clk) disable iff (reset)
        eng.done && !ctrlWrite && resultRead
        |=> resultReg == $past(resultReg) && pendValidReg)
        else $error("result changed under a colliding read");

    write_cancels_a: assert property (@(posedge core_clk) disable iff (reset)
        eng.done && ctrlWrite && !pendValidReg
        |=> !irqReg && resultReg == $past(resultReg))
        else $error("result or irq after colliding control write");

    normal_irq_a: assert property (@(posedge core_clk) disable iff (reset)
        eng.done && !ctrlWrite && !resultRead && !pfEnReg
        |=> irqReg ##1 !irqReg)
        else $error("normal mode irq missing or not a pulse");

    pol_zero_a: assert property (@(posedge core_clk) disable iff (reset)
        eng.done && !ctrlWrite && !resultRead && pfEnReg && !pfPolReg
        |=> irqReg == ($past(eng.value[9:2]) >= $past(threshReg)))
        else $error("polarity zero irq wrong");

    pol_one_a: assert property (@(posedge core_clk) disable iff (reset)
        eng.done && !ctrlWrite && !resultRead && pfEnReg && pfPolReg
        |=> irqReg == ($past(eng.value[9:2]) < $past(threshReg)))
        else $error("polarity one irq wrong");

    abort_restart_a: assert property (@(posedge core_clk) disable iff (reset)
        ctrlWrite |=> eng.restart ##1 !eng.done)
        else $error("control write did not restart conversion");

endmodule : sapc_control

// ---- sapc_eng_if.sv ----
`timescale 1ns/1ns

interface sapc_eng_if
    import sapc_pkg::*;
();
    logic run;
    logic restart;
    logic [4:0] unit;
    logic compare;
    logic hold;
    sapc_code_t tap;
    logic done;
    sapc_code_t value;

    modport ctrl
    (
        output run,
        output restart,
        output unit,
        output compare,
        input hold,
        input tap,
        input done,
        input value
    );

    modport eng
    (
        input run,
        input restart,
        input unit,
        input compare,
        output hold,
        output tap,
        output done,
        output value
    );
endinterface : sapc_eng_if

// ---- sapc_params.svh ----
`ifndef SAPC_PARAMS_SVH
`define SAPC_PARAMS_SVH

// ============================================================
// Register byte addresses
`define SAPC_ADDR_RES_LO 16'hff08
`define SAPC_ADDR_RES_HI 16'hff09
`define SAPC_ADDR_MODE 16'hff28
`define SAPC_ADDR_CHAN 16'hff29
`define SAPC_ADDR_PFM 16'hff2a
`define SAPC_ADDR_PFT 16'hff2b

// ============================================================
// Field positions and writable masks
`define SAPC_RUN_BIT 7
`define SAPC_REF_BIT 0
`define SAPC_FR_MSB 5
`define SAPC_FR_LSB 3
`define SAPC_POWERFAIL_COMPARE_ENABLE_BIT 7
`define SAPC_PFPOL_BIT 6
`define SAPC_MODE_MASK 8'hb9
`define SAPC_CHAN_MASK 8'h07
`define SAPC_PFM_MASK 8'hc0
`define SAPC_RES_SHIFT 6

// ============================================================
// Reset values
`define SAPC_MODE_RST 8'h00
`define SAPC_CHAN_RST 3'h0
`define SAPC_PFT_RST 8'h00

// ============================================================
// Conversion time: one trial unit is a twelfth of the total,
// sampling takes two units and each of the ten trials one
`define SAPC_UNIT_288 5'h18
`define SAPC_UNIT_240 5'h14
`define SAPC_UNIT_192 5'h10
`define SAPC_UNIT_144 5'h0c
`define SAPC_UNIT_120 5'h0a
`define SAPC_UNIT_96 5'h08
`define SAPC_FIRST_TRIAL 10'h200
`define SAPC_MSB_INDEX 4'h9

`endif

// ---- sapc_pkg.sv ----
package sapc_pkg;

    typedef enum logic [1:0]
    {
        SAPC_IDLE = 2'h0,
        SAPC_SAMPLE = 2'h1,
        SAPC_CONVERT = 2'h3
    } sapc_state_t;

    typedef logic [9:0] sapc_code_t;

endpackage : sapc_pkg

// ---- sapc_sar_engine.sv ----
`timescale 1ns/1ns
`include "sapc_params.svh"

module sapc_sar_engine
    import sapc_pkg::*;
(
    input wire logic core_clk,
    input wire logic reset,
    sapc_eng_if.eng bus
);

    sapc_state_t state;
    logic [5:0] cnt;
    logic [3:0] bitIdx;
    sapc_code_t sar;
    logic [5:0] sampleLast;
    logic [5:0] trialLast;
    sapc_code_t trialMask;
    sapc_code_t decided;

    assign sampleLast = {bus.unit, 1'b0} - 6'h01;
    assign trialLast = {1'b0, bus.unit} - 6'h01;
    assign trialMask = sapc_code_t'(10'h001 << bitIdx);
    // Keep the trial bit on input >= tap, otherwise drop it
    assign decided = bus.compare ? sar : (sar & ~trialMask);
    assign bus.tap = sar;

    // ========================================================
    // Sampling, hold and bit trials
    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            state <= SAPC_IDLE;
            cnt <= 6'h00;
            bitIdx <= 4'h0;
            sar <= 10'h000;
            bus.hold <= 1'b0;
            bus.done <= 1'b0;
            bus.value <= 10'h000;
        end
        else
        begin
            bus.done <= 1'b0;
            if (!bus.run)
            begin
                // Abandon at once; partial trial value is discarded
                state <= SAPC_IDLE;
                bus.hold <= 1'b0;
                cnt <= 6'h00;
            end
            else if (bus.restart || state == SAPC_IDLE)
            begin
                state <= SAPC_SAMPLE;
                bus.hold <= 1'b0;
                cnt <= 6'h00;
            end
            else
            begin
                case (state)
                    SAPC_SAMPLE:
                    begin
                        if (cnt == sampleLast)
                        begin
                            state <= SAPC_CONVERT;
                            bus.hold <= 1'b1;
                            cnt <= 6'h00;
                            bitIdx <= `SAPC_MSB_INDEX;
                            sar <= `SAPC_FIRST_TRIAL;
                        end
                        else
                        begin
                            cnt <= cnt + 6'h01;
                        end
                    end
                    SAPC_CONVERT:
                    begin
                        if (cnt == trialLast)
                        begin
                            cnt <= 6'h00;
                            if (bitIdx == 4'h0)
                            begin
                                bus.value <= decided;
                                bus.done <= 1'b1;
                                state <= SAPC_SAMPLE;
                                bus.hold <= 1'b0;
                            end
                            else
                            begin
                                sar <= decided | (trialMask >> 1);
                                bitIdx <= bitIdx - 4'h1;
                            end
                        end
                        else
                        begin
                            cnt <= cnt + 6'h01;
                        end
                    end
                    default:
                    begin
                        state <= SAPC_IDLE;
                    end
                endcase
            end
        end
    end

    hold_in_convert_a: assert property (@(posedge core_clk) disable iff (reset)
        state == SAPC_CONVERT |-> bus.hold)
        else $error("sample-hold not holding during trials");

    first_trial_a: assert property (@(posedge core_clk) disable iff (reset)
        state == SAPC_SAMPLE && cnt == sampleLast && bus.run
        && !bus.restart |=> bus.tap == 10'h200 && bitIdx == 4'h9)
        else $error("first trial is not bit nine at half scale");

    stop_idle_a: assert property (@(posedge core_clk) disable iff (reset)
        !bus.run |=> state == SAPC_IDLE && !bus.hold)
        else $error("conversion did not stop on run clear");

    back_to_back_a: assert property (@(posedge core_clk) disable iff (reset)
        bus.done |-> state == SAPC_SAMPLE && !bus.hold)
        else $error("next conversion did not resume sampling");

endmodule : sapc_sar_engine

// ---- testbench.sv ----
`timescale 1ns/1ns
`include "sapc_params.svh"

`define CHK(what, exp, got) \
    begin \
        compares++; \
        if ((got) !== (exp)) \
        begin \
            err_total++; \
            $display("wrong value %s exp %h got %h", what, exp, got); \
        end \
    end

module testbench;
    typedef struct {
        logic [2:0] ch;
        logic [9:0] lvl;
        logic [7:0] powerfail_mode_register;
        logic [7:0] th;
        logic irq;
    } sapc_row_t;

    logic core_clk;
    logic reset;
    logic [15:0] busAddr;
    logic busWrite;
    logic busRead;
    logic [7:0] busWrData;
    logic [7:0] busRdData;
    logic compIn;
    logic [2:0] channelSel;
    logic sampleHold;
    logic [9:0] tapCode;
    logic refGenEnable;
    logic conversionEndIrq;
    logic [9:0] chanLevel [8];
    logic [7:0] rdVal;
    int err_total;
    int compares;
    int cycleNo;
    int irqCount;
    int lastIrq;
    int irqGap;
    int snap;
    sapc_row_t rows [8];
    int units [7];
    logic [2:0] codes [7];

    sapc_control dut_u
    (
        .core_clk(core_clk),
        .reset(reset),
        .busAddr(busAddr),
        .busWrite(busWrite),
        .busRead(busRead),
        .busWrData(busWrData),
        .busRdData(busRdData),
        .compIn(compIn),
        .channelSel(channelSel),
        .sampleHold(sampleHold),
        .tapCode(tapCode),
        .refGenEnable(refGenEnable),
        .conversionEndIrq(conversionEndIrq)
    );

    sapc_analog_model model_u
    (
        .core_clk(core_clk),
        .channelSel(channelSel),
        .sampleHold(sampleHold),
        .tapCode(tapCode),
        .chanLevel(chanLevel),
        .compIn(compIn)
    );

    // ============================================================
    // Clock, interrupt monitor and hang guard
    initial
    begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    always @(posedge core_clk)
    begin
        cycleNo++;
        if (conversionEndIrq === 1'b1)
        begin
            irqCount++;
            irqGap = cycleNo - lastIrq;
            lastIrq = cycleNo;
        end
        if (cycleNo == 20000)
        begin
            err_total++;
            print_verdict();
        end
    end

    // ============================================================
    // Bus tasks
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(negedge core_clk);
        busAddr = a;
        busWrData = d;
        busWrite = 1'b1;
        @(negedge core_clk);
        busWrite = 1'b0;
    endtask : wr

    // Data is taken one and a half cycles after it settles, since it stands
    task automatic rd(input logic [15:0] a, output logic [7:0] d);
        @(negedge core_clk);
        busAddr = a;
        busRead = 1'b1;
        @(negedge core_clk);
        busRead = 1'b0;
        @(negedge core_clk);
        d = busRdData;
    endtask : rd

    task automatic waitCyc(input int n);
        repeat (n) @(negedge core_clk);
    endtask : waitCyc

    task automatic print_verdict();
        $display("compares %0d err_total %0d", compares, err_total);
        if (err_total == 0 && compares > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : print_verdict

    // ============================================================
    // Main sequence
    initial
    begin
        reset = 1'b1;
        busAddr = 16'h0000;
        busWrite = 1'b0;
        busRead = 1'b0;
        busWrData = 8'h00;
        for (int j = 0; j < 8; j++)
            chanLevel[j] = 10'h000;
        rows[0] = '{3'h0, 10'h3ff, 8'h00, 8'h00, 1'b1};
        rows[1] = '{3'h1, 10'h000, 8'h00, 8'hff, 1'b1};
        rows[2] = '{3'h2, 10'h2a5, 8'h80, 8'ha9, 1'b1};
        rows[3] = '{3'h3, 10'h2a5, 8'h80, 8'haa, 1'b0};
        rows[4] = '{3'h4, 10'h155, 8'hc0, 8'h56, 1'b1};
        rows[5] = '{3'h5, 10'h155, 8'hc0, 8'h55, 1'b0};
        rows[6] = '{3'h6, 10'h201, 8'h80, 8'h00, 1'b1};
        rows[7] = '{3'h7, 10'h1ff, 8'hc0, 8'h80, 1'b1};
        codes = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h5, 3'h6, 3'h7};
        units = '{24, 20, 16, 12, 10, 8, 24};
        repeat (16) @(negedge core_clk);
        reset = 1'b0;
        `CHK("idle outputs", 12'h000, {tapCode, sampleHold, refGenEnable})
        rd(`SAPC_ADDR_PFT, rdVal);
        `CHK("threshold reset", 8'h00, rdVal)
        wr(`SAPC_ADDR_PFT, 8'h5a);
        rd(`SAPC_ADDR_PFT, rdVal);
        `CHK("threshold rw", 8'h5a, rdVal)
        rd(16'hff2c, rdVal);
        `CHK("unmapped read", 8'h00, rdVal)
        wr(`SAPC_ADDR_MODE, 8'h01);
        // Reference needs 14 us to settle before the first start
        waitCyc(1400);

        // ========================================================
        // Table: one conversion per row, all channels and modes
        for (int i = 0; i < 8; i++)
        begin
            for (int j = 0; j < 8; j++)
                chanLevel[j] = (j == rows[i].ch) ? rows[i].lvl : ~rows[i].lvl;
            wr(`SAPC_ADDR_PFT, rows[i].th);
            wr(`SAPC_ADDR_PFM, rows[i].powerfail_mode_register);
            wr(`SAPC_ADDR_CHAN, {5'h00, rows[i].ch});
            irqCount = 0;
            wr(`SAPC_ADDR_MODE, 8'hb1);
            waitCyc(150);
            `CHK("irq count", rows[i].irq ? 1 : 0, irqCount)
            wr(`SAPC_ADDR_MODE, 8'h01);
            `CHK("channel", rows[i].ch, channelSel)
            rd(`SAPC_ADDR_RES_HI, rdVal);
            `CHK("result high", rows[i].lvl[9:2], rdVal)
            rd(`SAPC_ADDR_RES_LO, rdVal);
            `CHK("result low", {rows[i].lvl[1:0], 6'h00}, rdVal)
        end

        // ========================================================
        // Conversion time per code, back-to-back spacing, sampling
        // Code 7 is prohibited and must fall back to the slowest time
        wr(`SAPC_ADDR_PFM, 8'h00);
        for (int k = 0; k < 7; k++)
        begin
            irqCount = 0;
            wr(`SAPC_ADDR_MODE, {2'b10, codes[k], 3'b001});
            for (int w = 0; w < 2000 && irqCount < 2; w++)
                waitCyc(1);
            `CHK("irq pair", 2, irqCount)
            `CHK("irq spacing", 12 * units[k], irqGap)
            waitCyc(units[k]);
            `CHK("sampling", 1'b0, sampleHold)
            `CHK("reference enable", 1'b1, refGenEnable)
            waitCyc(2 * units[k]);
            `CHK("holding", 1'b1, sampleHold)
            `CHK("second trial tap", 10'h100, tapCode)
            wr(`SAPC_ADDR_MODE, 8'h01);
        end

        // ========================================================
        // Abort by a threshold write, then stop in mid-conversion
        irqCount = 0;
        wr(`SAPC_ADDR_MODE, 8'hb1);
        waitCyc(80);
        wr(`SAPC_ADDR_PFT, 8'h00);
        waitCyc(80);
        `CHK("irq after abort", 0, irqCount)
        waitCyc(30);
        `CHK("irq after restart", 1, irqCount)
        // Same-value channel write lands on the finishing cycle
        waitCyc(82);
        wr(`SAPC_ADDR_CHAN, 8'h07);
        waitCyc(60);
        `CHK("irq after collision", 1, irqCount)
        wr(`SAPC_ADDR_MODE, 8'h01);
        snap = irqCount;
        waitCyc(200);
        `CHK("irq after stop", snap, irqCount)
        `CHK("stopped sampling", 1'b0, sampleHold)

        // ========================================================
        // Unread result overwritten by the next conversion
        wr(`SAPC_ADDR_CHAN, 8'h00);
        chanLevel[0] = 10'h100;
        wr(`SAPC_ADDR_MODE, 8'hb1);
        waitCyc(60);
        chanLevel[0] = 10'h2cc;
        waitCyc(36);
        // Read lands on the finishing cycle: old value, then the new one
        rd(`SAPC_ADDR_RES_HI, rdVal);
        `CHK("read before latch", 8'h7f, rdVal)
        rd(`SAPC_ADDR_RES_HI, rdVal);
        `CHK("first result", 8'h40, rdVal)
        waitCyc(40);
        chanLevel[0] = 10'h0f0;
        // The second result is never read before the third lands
        waitCyc(150);
        rd(`SAPC_ADDR_RES_HI, rdVal);
        `CHK("newer result", 8'h3c, rdVal)
        wr(`SAPC_ADDR_MODE, 8'h01);
        wr(`SAPC_ADDR_MODE, 8'h00);

        // ========================================================
        // Second reset clears the threshold again
        wr(`SAPC_ADDR_PFT, 8'h3c);
        @(negedge core_clk);
        reset = 1'b1;
        repeat (16) @(negedge core_clk);
        reset = 1'b0;
        rd(`SAPC_ADDR_PFT, rdVal);
        `CHK("threshold second reset", 8'h00, rdVal)
        print_verdict();
    end
endmodule : testbench
